// [core/tcap_pkg.sv]
// Package: register map, field positions, reset values and bus carriers
package tcap_pkg;

    // ==================================================
    // Register map (byte addresses)
    // ==================================================
    localparam logic [7:0] CONTROL_INDEX = 8'h17;
    localparam logic [11:0] CONTROL_ADDR = {2'h0, CONTROL_INDEX, 2'h0};
    localparam logic [11:0] CASCADE_ADDR = 12'h100;
    localparam logic [11:0] THIRD_TIMER_ADDR = 12'h104;
    localparam logic [11:0] FIRST_SECOND_TIMER_ADDR = 12'h108;
    localparam logic [11:0] SHARED_PAIR_ADDR = 12'h10C;
    localparam logic [11:0] SECOND_PAIR_ADDR = 12'h110;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h114;
    localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h118;
    localparam logic [11:0] IRQ_CLEAR_ADDR = 12'h11C;
    localparam logic [11:0] DIRECTION_ADDR = 12'h120;

    // ==================================================
    // Control register fields
    // ==================================================
    localparam int SECOND_OVF_BIT = 7;
    localparam int FIRST_OVF_BIT = 6;
    localparam int SECOND_PWM_BIT = 5;
    localparam int FIRST_PWM_BIT = 4;
    localparam int SHARED_SEL_BIT = 3;
    localparam int THIRD_RUN_BIT = 2;
    localparam int SECOND_RUN_BIT = 1;
    localparam int FIRST_RUN_BIT = 0;
    localparam int SECOND_PIN_DIR_BIT = 3;
    localparam int FIRST_PIN_DIR_BIT = 2;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

    // Interrupt status bits
    localparam int IRQ_FIRST_CAPTURE = 0;
    localparam int IRQ_SECOND_CAPTURE = 1;
    localparam int IRQ_FIRST_OVF = 2;
    localparam int IRQ_SECOND_OVF = 3;
    localparam int IRQ_THIRD_WRAP = 4;
    localparam int IRQ_COUNT = 5;

    // Synchroniser depth
    localparam int SYNC_STAGES = 3;

    // ==================================================
    // Carriers
    // ==================================================
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

endpackage : tcap_pkg

// [core/capture_channel.sv]
// One capture channel: latch with overrun and two-byte read release
`timescale 1ns/1ns
module capture_channel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Event and source
    input wire logic enable,
    input wire logic capture_pulse,
    input wire logic [15:0] timer_value,
    // Software reads of the pair
    input wire logic read_low,
    input wire logic read_high,
    // State
    output logic [15:0] captured,
    output logic overrun,
    output logic accepted,
    output logic overrun_pulse
);

    logic unread;
    logic low_read;
    logic high_read;
    logic both_read;

    assign both_read = (low_read | read_low) & (high_read | read_high);
    assign accepted = enable & capture_pulse & ~overrun & (~unread | both_read);
    assign overrun_pulse = enable & capture_pulse & unread & ~both_read & ~overrun;

    // ==================================================
    // Captured value
    // ==================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured <= 16'h0000;
        end else if (clk_en) begin
            if (accepted) begin
                captured <= timer_value;
            end
        end
    end

    // ==================================================
    // Unread tracking and overrun
    // ==================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unread <= 1'b0;
            low_read <= 1'b0;
            high_read <= 1'b0;
            overrun <= 1'b0;
        end else if (clk_en) begin
            if (accepted) begin
                unread <= 1'b1;
                low_read <= 1'b0;
                high_read <= 1'b0;
            end else if (unread && both_read) begin
                unread <= 1'b0;
                low_read <= 1'b0;
                high_read <= 1'b0;
            end else if (unread) begin
                low_read <= low_read | read_low;
                high_read <= high_read | read_high;
            end
            if (overrun_pulse) begin
                overrun <= 1'b1;
            end else if (unread && both_read) begin
                overrun <= 1'b0;
            end
        end
    end

endmodule : capture_channel

// [core/timer_capture_control.sv]
// Timer/capture/PWM control register block with three timers and APB access
//
// Functional notes
// - Bit 7 flags second capture overrun when unread value is recaptured.
// - Bit 6 flags first capture overrun likewise on the shared pair.
// - After overrun keep oldest value; ignore captures until both bytes read.
// - Accepted capture loads the pair with the third timer count.
// - Bit 5 drives second pulse pin; else direction bit 3 rules.
// - Bit 4 drives first pulse pin; else direction bit 2 rules.
// - Bit 3 picks capture use of shared pair; clear means period.
// - Bit 2 runs the third timer; clear halts it.
// - In 8-bit mode bit 1 alone lets the second timer increment.
// - In cascade the upper byte advances only with bit 1 set.
// - In cascade bit 0 starts and stops the combined timer.
// - Overrun bits read-only, other six read/write, all zero at reset.
// - Mode select one cascades timers; zero keeps two 8-bit timers.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
module timer_capture_control (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire tcap_pkg::apb_req_t apb_req,
    output tcap_pkg::apb_rsp_t apb_rsp,
    // Capture pins (asynchronous)
    input wire logic first_capture_pin,
    input wire logic second_capture_pin,
    // Pulse generator outputs from the PWM logic
    input wire logic first_pulse_value,
    input wire logic second_pulse_value,
    // Port latch values for the shared pins
    input wire logic first_port_latch,
    input wire logic second_port_latch,
    // Pins
    output tcap_pkg::pin_drive_t first_pulse_pin,
    output tcap_pkg::pin_drive_t second_pulse_pin,
    // Interrupt
    output logic irq
);

    logic [7:0] timer_pwm_capture_control;
    logic cascade_mode_select;
    logic [7:0] port_direction_bits;
    logic [7:0] first_timer_count;
    logic [7:0] second_timer_count;
    logic [15:0] third_timer_count;
    localparam int IRQ_W = tcap_pkg::IRQ_COUNT;
    logic [15:0] period_value;
    logic [5:0] control_bits;
    logic [31:0] read_word;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;

    logic first_run;
    logic second_run;
    logic third_run;
    logic shared_sel;
    logic first_ovf;
    logic second_ovf;
    logic [15:0] first_captured;
    logic [15:0] second_captured;
    logic first_accepted;
    logic second_accepted;
    logic first_ovf_pulse;
    logic second_ovf_pulse;
    logic third_wrap;

    // ==================================================
    // APB decode
    // ==================================================
    logic wr_en;
    logic rd_en;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic mapped;

    assign addr = apb_req.paddr;
    assign wdata = apb_req.pwdata;
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & clk_en;
    assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite & clk_en;

    assign first_run = timer_pwm_capture_control[tcap_pkg::FIRST_RUN_BIT];
    assign second_run = timer_pwm_capture_control[tcap_pkg::SECOND_RUN_BIT];
    assign third_run = timer_pwm_capture_control[tcap_pkg::THIRD_RUN_BIT];
    assign shared_sel = timer_pwm_capture_control[tcap_pkg::SHARED_SEL_BIT];

    // ==================================================
    // Capture pin synchronisers
    // ==================================================
    logic [tcap_pkg::SYNC_STAGES-1:0] first_sync;
    logic [tcap_pkg::SYNC_STAGES-1:0] second_sync;
    logic first_level;
    logic second_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_sync <= 3'h0;
            second_sync <= 3'h0;
            first_level <= 1'b0;
            second_level <= 1'b0;
        end else if (clk_en) begin
            first_sync <= {first_sync[1:0], first_capture_pin};
            second_sync <= {second_sync[1:0], second_capture_pin};
            if (first_sync[1] == first_sync[2]) begin
                first_level <= first_sync[2];
            end
            if (second_sync[1] == second_sync[2]) begin
                second_level <= second_sync[2];
            end
        end
    end

    // Rising edge of the filtered level is a capture event
    logic first_level_d;
    logic second_level_d;
    logic first_event;
    logic second_event;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_level_d <= 1'b0;
            second_level_d <= 1'b0;
        end else if (clk_en) begin
            first_level_d <= first_level;
            second_level_d <= second_level;
        end
    end

    assign first_event = first_level & ~first_level_d;
    assign second_event = second_level & ~second_level_d;

    // ==================================================
    // Capture channels
    // ==================================================
    logic shared_low_rd;
    logic shared_high_rd;
    logic second_low_rd;
    logic second_high_rd;

    // Byte reads: one word read of the pair counts as both low and high byte read
    assign shared_low_rd = rd_en & (addr == tcap_pkg::SHARED_PAIR_ADDR) & shared_sel;
    assign shared_high_rd = shared_low_rd;
    assign second_low_rd = rd_en & (addr == tcap_pkg::SECOND_PAIR_ADDR);
    assign second_high_rd = second_low_rd;

    // capture only when shared pair selects capture
    capture_channel first_channel (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .enable(shared_sel),
        .capture_pulse(first_event),
        .timer_value(third_timer_count),
        .read_low(shared_low_rd),
        .read_high(shared_high_rd),
        .captured(first_captured),
        .overrun(first_ovf),
        .accepted(first_accepted),
        .overrun_pulse(first_ovf_pulse)
    );

    capture_channel second_channel (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .enable(1'b1),
        .capture_pulse(second_event),
        .timer_value(third_timer_count),
        .read_low(second_low_rd),
        .read_high(second_high_rd),
        .captured(second_captured),
        .overrun(second_ovf),
        .accepted(second_accepted),
        .overrun_pulse(second_ovf_pulse)
    );

    // ==================================================
    // Control and configuration registers
    // ==================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_bits <= tcap_pkg::CONTROL_RESET[5:0];
            cascade_mode_select <= 1'b0;
            port_direction_bits <= tcap_pkg::DIRECTION_RESET;
            period_value <= tcap_pkg::PERIOD_RESET;
            irq_enable <= '0;
        end else if (wr_en) begin
            unique case (addr)
                tcap_pkg::CONTROL_ADDR: control_bits <= wdata[5:0];
                tcap_pkg::CASCADE_ADDR: cascade_mode_select <= wdata[0];
                tcap_pkg::DIRECTION_ADDR: port_direction_bits <= wdata[7:0];
                tcap_pkg::IRQ_ENABLE_ADDR: irq_enable <= wdata[IRQ_W-1:0];
                tcap_pkg::SHARED_PAIR_ADDR: begin
                    if (!shared_sel) begin
                        period_value <= wdata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // overrun bits mirror hardware state, read-only
    assign timer_pwm_capture_control = {second_ovf, first_ovf, control_bits};

    // ==================================================
    // First and second timers
    // ==================================================
    logic first_tick;
    logic second_tick;

    // bit 0 runs the combined timer
    // bit 0 runs only the first timer in 8-bit mode
    assign first_tick = first_run;
    // second timer gated by its run bit
    // upper byte needs bit 1 in cascade
    assign second_tick = cascade_mode_select ? (first_run & second_run & (first_timer_count == 8'hFF)) : second_run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_timer_count <= 8'h00;
            second_timer_count <= 8'h00;
        end else if (clk_en) begin
            if (wr_en && addr == tcap_pkg::FIRST_SECOND_TIMER_ADDR) begin
                first_timer_count <= wdata[7:0];
                second_timer_count <= wdata[15:8];
            end else begin
                if (first_tick) begin
                    first_timer_count <= first_timer_count + 8'h01;
                end
                if (second_tick) begin
                    second_timer_count <= second_timer_count + 8'h01;
                end
            end
        end
    end

    // ==================================================
    // Third timer
    // ==================================================
    // period limit only in period mode
    assign third_wrap = third_run & (shared_sel ? (third_timer_count == 16'hFFFF) :
                                     (third_timer_count == period_value));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            third_timer_count <= 16'h0000;
        end else if (clk_en) begin
            if (wr_en && addr == tcap_pkg::THIRD_TIMER_ADDR) begin
                third_timer_count <= wdata[15:0];
            end else if (third_run) begin
                third_timer_count <= third_wrap ? 16'h0000 : third_timer_count + 16'h0001;
            end
        end
    end

    // ==================================================
    // Pulse pins
    // ==================================================
    // second pin override
    assign second_pulse_pin.oe = timer_pwm_capture_control[tcap_pkg::SECOND_PWM_BIT] |
                                 ~port_direction_bits[tcap_pkg::SECOND_PIN_DIR_BIT];
    assign second_pulse_pin.out = timer_pwm_capture_control[tcap_pkg::SECOND_PWM_BIT] ?
                                  second_pulse_value : second_port_latch;
    assign first_pulse_pin.oe = timer_pwm_capture_control[tcap_pkg::FIRST_PWM_BIT] |
                                ~port_direction_bits[tcap_pkg::FIRST_PIN_DIR_BIT];
    assign first_pulse_pin.out = timer_pwm_capture_control[tcap_pkg::FIRST_PWM_BIT] ?
                                 first_pulse_value : first_port_latch;

    // ==================================================
    // Interrupts
    // ==================================================
    logic [IRQ_W-1:0] irq_events;

    assign irq_events = {third_wrap & clk_en, second_ovf_pulse & clk_en, first_ovf_pulse & clk_en,
                         second_accepted & clk_en, first_accepted & clk_en};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else begin
            // Set wins over a same-cycle clear
            if (wr_en && addr == tcap_pkg::IRQ_CLEAR_ADDR) begin
                irq_status <= (irq_status & ~wdata[IRQ_W-1:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ==================================================
    // Read data
    // ==================================================
    always_comb begin
        rdata = 32'h0000_0000;
        mapped = 1'b1;
        unique case (addr)
            tcap_pkg::CONTROL_ADDR: rdata[7:0] = timer_pwm_capture_control;
            tcap_pkg::CASCADE_ADDR: rdata[0] = cascade_mode_select;
            tcap_pkg::DIRECTION_ADDR: rdata[7:0] = port_direction_bits;
            tcap_pkg::FIRST_SECOND_TIMER_ADDR: rdata[15:0] = {second_timer_count, first_timer_count};
            tcap_pkg::THIRD_TIMER_ADDR: rdata[15:0] = third_timer_count;
            tcap_pkg::SHARED_PAIR_ADDR: rdata[15:0] = shared_sel ? first_captured : period_value;
            tcap_pkg::SECOND_PAIR_ADDR: rdata[15:0] = second_captured;
            tcap_pkg::IRQ_STATUS_ADDR: rdata[IRQ_W-1:0] = irq_status;
            tcap_pkg::IRQ_ENABLE_ADDR: rdata[IRQ_W-1:0] = irq_enable;
            tcap_pkg::IRQ_CLEAR_ADDR: rdata = 32'h0000_0000;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_word <= 32'h0000_0000;
        end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite && clk_en) begin
            read_word <= rdata;
        end
    end

    assign apb_rsp.prdata = read_word;
    assign apb_rsp.pready = apb_req.psel & apb_req.penable & clk_en;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;

endmodule : timer_capture_control

// [test/tcap_chk.sv]
// Checker: APB handshake, control readback and pulse pin ownership
`timescale 1ns/1ns
module tcap_chk (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB
    input wire tcap_pkg::apb_req_t apb_req,
    input wire tcap_pkg::apb_rsp_t apb_rsp,
    // Capture pins
    input wire logic first_capture_pin,
    input wire logic second_capture_pin,
    // Pulse sources and port latches
    input wire logic first_pulse_value,
    input wire logic second_pulse_value,
    input wire logic first_port_latch,
    input wire logic second_port_latch,
    // Pins and interrupt
    input wire tcap_pkg::pin_drive_t first_pulse_pin,
    input wire tcap_pkg::pin_drive_t second_pulse_pin,
    input wire logic irq
);
    // ==================================================
    // Shadow of the writable control and direction bits
    // ==================================================
    logic [5:0] ctl;
    logic [7:0] dir;
    logic wr_go;
    assign wr_go = apb_req.psel && apb_req.penable && clk_en && apb_req.pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 6'h00;
        end else if (wr_go && apb_req.paddr == tcap_pkg::CONTROL_ADDR) begin
            ctl <= apb_req.pwdata[5:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir <= 8'hFF;
        end else if (wr_go && apb_req.paddr == tcap_pkg::DIRECTION_ADDR) begin
            dir <= apb_req.pwdata[7:0];
        end
    end
    // ==================================================
    // Assertions
    // ==================================================
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence access_s;
        apb_req.psel && apb_req.penable && clk_en;
    endsequence
    sequence ctl_read_s;
        setup_s and !apb_req.pwrite && apb_req.paddr == tcap_pkg::CONTROL_ADDR;
    endsequence
    a_zero_wait: assert property (setup_s ##1 access_s |-> apb_rsp.pready)
        else $error("pready late");
    a_err_access: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
        else $error("pslverr outside access");
    a_ctl_readback: assert property (ctl_read_s ##1 access_s |-> apb_rsp.prdata[5:0] == ctl)
        else $error("control readback wrong");
    a_prdata_hold: assert property (!(apb_req.psel && !apb_req.penable && !apb_req.pwrite && clk_en) |=>
        $stable(apb_rsp.prdata))
        else $error("prdata changed");
    a_first_pin_oe: assert property (first_pulse_pin.oe == (ctl[4] || !dir[2]))
        else $error("first pin enable wrong");
    a_first_pin_out: assert property (first_pulse_pin.out == (ctl[4] ? first_pulse_value : first_port_latch))
        else $error("first pin value wrong");
    a_second_pin_oe: assert property (second_pulse_pin.oe == (ctl[5] || !dir[3]))
        else $error("second pin enable wrong");
    a_second_pin_out: assert property (second_pulse_pin.out == (ctl[5] ? second_pulse_value : second_port_latch))
        else $error("second pin value wrong");
endmodule : tcap_chk

bind timer_capture_control tcap_chk chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .first_capture_pin(first_capture_pin),
    .second_capture_pin(second_capture_pin), .first_pulse_value(first_pulse_value),
    .second_pulse_value(second_pulse_value), .first_port_latch(first_port_latch),
    .second_port_latch(second_port_latch), .first_pulse_pin(first_pulse_pin),
    .second_pulse_pin(second_pulse_pin), .irq(irq));

// [test/testbench.sv]
// Testbench: registers, timer gating, capture overrun and interrupt
`timescale 1ns/1ns
module testbench;
    localparam logic [11:0] CTL = tcap_pkg::CONTROL_ADDR;
    localparam logic [11:0] T3 = tcap_pkg::THIRD_TIMER_ADDR;
    localparam logic [11:0] T12 = tcap_pkg::FIRST_SECOND_TIMER_ADDR;
    localparam logic [11:0] SHP = tcap_pkg::SHARED_PAIR_ADDR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    tcap_pkg::apb_req_t req = '0;
    tcap_pkg::apb_rsp_t rsp;
    logic cap1 = 1'b0;
    logic cap2 = 1'b0;
    logic [3:0] pv = 4'h0;
    tcap_pkg::pin_drive_t p1;
    tcap_pkg::pin_drive_t p2;
    logic irq;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h16;
    logic [31:0] rd;
    logic err;
    logic [31:0] t;
    logic [31:0] u;
    timer_capture_control dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req),
        .apb_rsp(rsp), .first_capture_pin(cap1), .second_capture_pin(cap2), .first_pulse_value(pv[0]),
        .second_pulse_value(pv[1]), .first_port_latch(pv[2]), .second_port_latch(pv[3]),
        .first_pulse_pin(p1), .second_pulse_pin(p2), .irq(irq));
    always #5 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] step(input logic [31:0] a, input logic [31:0] b, input logic bw);
        if (bw) begin
            return {16'h0, b[15:8] - a[15:8], b[7:0] - a[7:0]};
        end
        return {16'h0, b[15:0] - a[15:0]};
    endfunction : step
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    always @(posedge pclk) begin
        pv <= 4'(rnd());
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // ==================================================
    // APB master
    // ==================================================
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic run(input logic c, input logic [31:0] v, input logic [11:0] a, input logic bw,
                       input logic [31:0] e);
        apb(1'b1, tcap_pkg::CASCADE_ADDR, {31'h0, c});
        apb(1'b1, CTL, v);
        apb(1'b0, a, 32'h0);
        t = rd;
        apb(1'b0, a, 32'h0);
        chk(step(t, rd, bw), e, "count step");
    endtask : run
    task automatic pulse(input int ch);
        @(posedge pclk);
        cap1 <= (ch == 0);
        cap2 <= (ch == 1);
        repeat (8) @(posedge pclk);
        cap1 <= 1'b0;
        cap2 <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : pulse
    // ==================================================
    // Main sequence
    // ==================================================
    initial begin
        logic [11:0] pa;
        int ob;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTL, 32'h0);
        chk(rd, 32'h0, "control reset");
        apb(1'b0, tcap_pkg::DIRECTION_ADDR, 32'h0);
        chk(rd, 32'hFF, "direction reset");
        apb(1'b0, 12'h7F0, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped read");
        for (int i = 0; i < 8; i++) begin
            t = rnd();
            apb(1'b1, tcap_pkg::DIRECTION_ADDR, t);
            apb(1'b1, CTL, t | 32'hC0);
            apb(1'b0, CTL, 32'h0);
            chk(rd, {26'h0, t[5:0]}, "control write");
            repeat (4) @(posedge pclk);
        end
        run(1'b0, 32'h4, T3, 1'b0, 32'h3);
        apb(1'b0, T3, 32'h0);
        t = rd;
        clk_en <= 1'b0;
        repeat (20) @(posedge pclk);
        clk_en <= 1'b1;
        apb(1'b0, T3, 32'h0);
        chk(step(t, rd, 1'b0), 32'h3, "clock enable freeze");
        run(1'b0, 32'h0, T3, 1'b0, 32'h0);
        run(1'b0, 32'h1, T12, 1'b1, 32'h3);
        run(1'b0, 32'h2, T12, 1'b1, 32'h300);
        run(1'b0, 32'h0, T12, 1'b1, 32'h0);
        run(1'b1, 32'h3, T12, 1'b0, 32'h3);
        run(1'b1, 32'h2, T12, 1'b0, 32'h0);
        run(1'b1, 32'h1, T12, 1'b1, 32'h3);
        apb(1'b1, SHP, 32'h10);
        apb(1'b1, T3, 32'h0);
        apb(1'b1, CTL, 32'h4);
        for (int i = 0; i < 8; i++) begin
            repeat (rnd() % 8) @(posedge pclk);
            apb(1'b0, T3, 32'h0);
            chk({31'h0, rd[15:0] <= 16'h10}, 32'h1, "period limit");
        end
        apb(1'b1, CTL, 32'hC);
        repeat (40) @(posedge pclk);
        apb(1'b0, T3, 32'h0);
        chk({31'h0, rd[15:0] > 16'h10}, 32'h1, "free run");
        apb(1'b1, tcap_pkg::IRQ_ENABLE_ADDR, 32'h3);
        for (int ch = 0; ch < 2; ch++) begin
            pa = ch ? tcap_pkg::SECOND_PAIR_ADDR : SHP;
            ob = ch ? 7 : 6;
            apb(1'b1, tcap_pkg::IRQ_CLEAR_ADDR, 32'h1F);
            @(posedge pclk);
            chk({31'h0, irq}, 32'h0, "irq cleared");
            apb(1'b0, T3, 32'h0);
            t = rd;
            pulse(ch);
            chk({31'h0, irq}, 32'h1, "irq raised");
            apb(1'b0, T3, 32'h0);
            u = rd;
            pulse(ch);
            apb(1'b0, CTL, 32'h0);
            chk({31'h0, rd[ob]}, 32'h1, "overrun set");
            apb(1'b0, pa, 32'h0);
            chk({31'h0, rd[15:0] > t[15:0] && rd[15:0] < u[15:0]}, 32'h1, "oldest kept");
            apb(1'b0, CTL, 32'h0);
            chk({31'h0, rd[ob]}, 32'h0, "overrun cleared");
            pulse(ch);
            apb(1'b0, pa, 32'h0);
            chk({31'h0, rd[15:0] > u[15:0]}, 32'h1, "capture rearmed");
        end
        apb(1'b1, tcap_pkg::IRQ_ENABLE_ADDR, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, CTL, 32'h4);
        apb(1'b1, tcap_pkg::IRQ_CLEAR_ADDR, 32'h1F);
        pulse(0);
        pulse(1);
        apb(1'b0, tcap_pkg::IRQ_STATUS_ADDR, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h2, "period mode capture");
        results();
    end
endmodule : testbench
